// file: core/bbt_map.vh
`ifndef BBT_MAP_VH
`define BBT_MAP_VH

// ----------------------------------------------------------------
// Register offsets (register port address units)
// ----------------------------------------------------------------
`define BBT_ADDR_W            12
`define BBT_OFS_TEST_CTRL     12'h0BF
`define BBT_OFS_LOCAL_ERR     12'h0C7
`define BBT_OFS_SEND_START    12'h0C8
`define BBT_OFS_SEND_LEN      12'h0C9
`define BBT_OFS_RECV_LEN      12'h0CA
`define BBT_OFS_RECV_START    12'h0CB

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BBT_STREAM_HI         13
`define BBT_STREAM_LO         9
`define BBT_CHAN_HI           8
`define BBT_CHAN_LO           0
`define BBT_LEN_HI            8
`define BBT_LEN_LO            0
`define BBT_CTRL_CLEAR_BIT    0
`define BBT_CTRL_SEND_EN_BIT  1
`define BBT_CTRL_RECV_EN_BIT  2

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define BBT_RST_REG16         16'h0000
`define BBT_RST_CTRL          3'h0
`define BBT_ERR_MAX           16'hFFFF
`define BBT_READ_NONE         16'h0000

// ----------------------------------------------------------------
// Test sequence generator
// ----------------------------------------------------------------
`define BBT_SEQ_WIDTH         15
`define BBT_SEQ_TAP_A         14
`define BBT_SEQ_TAP_B         13
`define BBT_SEQ_SEED          15'h7FFF

`endif

// file: core/bbt_seq.v
`include "bbt_map.vh"
`default_nettype none

// Test sequence engine: generator, or self-synchronising checker
module bbt_seq #(
   parameter WIDTH = `BBT_SEQ_WIDTH,
   parameter TAP_A = `BBT_SEQ_TAP_A,
   parameter TAP_B = `BBT_SEQ_TAP_B
) (
   // Clock and reset
   input  wire clk_i,
   input  wire reset_n_i,
   // Control
   input  wire step_i,
   input  wire check_i,
   input  wire rx_bit_i,
   // Results
   output reg  bit_o,
   output reg  err_o
);

   // ----------------------------------------------------------------
   // Shift register
   // ----------------------------------------------------------------
   reg  [WIDTH-1:0] shift_reg;
   wire             feedback;

   // Next sequence bit from two taps
   assign feedback = shift_reg[TAP_A] ^ shift_reg[TAP_B];

   // Generator feeds back, checker loads received bits
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shift_reg <= `BBT_SEQ_SEED;
         bit_o     <= 1'b0;
         err_o     <= 1'b0;
      end else begin
         err_o <= 1'b0;
         if (step_i) begin
            bit_o <= feedback;
            if (check_i) begin
               shift_reg <= {shift_reg[WIDTH-2:0], rx_bit_i};
               err_o     <= rx_bit_i ^ feedback; // Mismatch flag
            end else begin
               shift_reg <= {shift_reg[WIDTH-2:0], feedback};
            end
         end
      end
   end

endmodule

`default_nettype wire

// file: core/bbt_top.v
`include "bbt_map.vh"
`default_nettype none

module bbt_top #(
   parameter STREAMS = 32
) (
   // Clock and reset
   input  wire                   clk_i,
   input  wire                   reset_n_i,
   // Register port
   input  wire [`BBT_ADDR_W-1:0] reg_addr_i,
   input  wire                   reg_wr_i,
   input  wire                   reg_rd_i,
   input  wire [15:0]            reg_wdata_i,
   output reg  [15:0]            reg_rdata_o,
   output reg                    reg_rvalid_o,
   // Frame timing
   input  wire                   frame_start_i,
   // Backplane output side
   input  wire                   bp_tx_bit_en_i,
   input  wire [8:0]             bp_tx_channel_i,
   output reg  [4:0]             bp_tx_stream_o,
   output reg                    bp_tx_insert_o,
   output wire                   bp_tx_data_o,
   // Backplane input side
   input  wire                   bp_rx_bit_en_i,
   input  wire [8:0]             bp_rx_channel_i,
   input  wire [STREAMS-1:0]     bp_rx_data_i,
   output wire                   bp_bit_error_o,
   // Local checker events
   input  wire                   local_bit_error_i
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // True when channel lies in the span start .. start+len
   function in_window;
      input [8:0] ch;
      input [8:0] start;
      input [8:0] len;
      reg   [9:0] last;
      begin
         // Ten-bit sum, so a span never wraps past the last channel
         last      = {1'b0, start} + {1'b0, len};
         in_window = ({1'b0, ch} >= {1'b0, start}) && ({1'b0, ch} <= last);
      end
   endfunction

   // Pick one stream bit, zero for a stream that does not exist
   function pick_stream;
      input [STREAMS-1:0] data;
      input [4:0]         idx;
      integer             k;
      begin
         // Out-of-range index matches no stream and stays zero
         pick_stream = 1'b0;
         for (k = 0; k < STREAMS; k = k + 1) begin
            if (idx == k[4:0]) begin
               pick_stream = data[k];
            end
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   reg  [15:0] local_error_count_reg;
   reg  [15:0] local_error_count_next;
   reg  [4:0]  bp_send_stream_reg;
   reg  [8:0]  bp_send_channel_reg;
   reg  [8:0]  bp_send_length_reg;
   reg  [8:0]  bp_receive_length_reg;
   reg  [4:0]  bp_receive_stream_reg;
   reg  [8:0]  bp_receive_channel_reg;
   reg         send_enable_reg;
   reg         receive_enable_reg;
   wire        local_count_clear;

   // Write decode
   // Writes to the count or to unmapped offsets are dropped
   wire wr_ctrl       = reg_wr_i && (reg_addr_i == `BBT_OFS_TEST_CTRL);
   wire wr_send_start = reg_wr_i && (reg_addr_i == `BBT_OFS_SEND_START);
   wire wr_send_len   = reg_wr_i && (reg_addr_i == `BBT_OFS_SEND_LEN);
   wire wr_recv_len   = reg_wr_i && (reg_addr_i == `BBT_OFS_RECV_LEN);
   wire wr_recv_start = reg_wr_i && (reg_addr_i == `BBT_OFS_RECV_START);

   // Clear is a write-one strobe, never stored
   assign local_count_clear = wr_ctrl && reg_wdata_i[`BBT_CTRL_CLEAR_BIT];

   // Configuration registers; reserved bits are not stored
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bp_send_stream_reg     <= 5'h00;
         bp_send_channel_reg    <= 9'h000;
         bp_send_length_reg     <= 9'h000;
         bp_receive_length_reg  <= 9'h000;
         bp_receive_stream_reg  <= 5'h00;
         bp_receive_channel_reg <= 9'h000;
         send_enable_reg        <= 1'b0;
         receive_enable_reg     <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            send_enable_reg    <= reg_wdata_i[`BBT_CTRL_SEND_EN_BIT];
            receive_enable_reg <= reg_wdata_i[`BBT_CTRL_RECV_EN_BIT];
         end
         if (wr_send_start) begin
            bp_send_stream_reg  <= reg_wdata_i[`BBT_STREAM_HI:`BBT_STREAM_LO];
            bp_send_channel_reg <= reg_wdata_i[`BBT_CHAN_HI:`BBT_CHAN_LO];
         end
         if (wr_send_len) begin
            bp_send_length_reg <= reg_wdata_i[`BBT_LEN_HI:`BBT_LEN_LO];
         end
         if (wr_recv_len) begin
            bp_receive_length_reg <= reg_wdata_i[`BBT_LEN_HI:`BBT_LEN_LO];
         end
         if (wr_recv_start) begin
            bp_receive_stream_reg  <= reg_wdata_i[`BBT_STREAM_HI:`BBT_STREAM_LO];
            bp_receive_channel_reg <= reg_wdata_i[`BBT_CHAN_HI:`BBT_CHAN_LO];
         end
      end
   end

   // ----------------------------------------------------------------
   // Local error counter
   // ----------------------------------------------------------------

   // Saturating count; an error in the clear cycle is kept
   always @* begin
      local_error_count_next = local_error_count_reg;
      if (local_count_clear) begin
         local_error_count_next = local_bit_error_i ? 16'h0001 : `BBT_RST_REG16;
      end else if (local_bit_error_i && (local_error_count_reg != `BBT_ERR_MAX)) begin
         local_error_count_next = local_error_count_reg + 16'h0001;
      end
   end

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         local_error_count_reg <= `BBT_RST_REG16;
      end else begin
         local_error_count_reg <= local_error_count_next;
      end
   end

   // ----------------------------------------------------------------
   // Register read-back
   // ----------------------------------------------------------------
   reg [15:0] read_mux;

   // Reserved and unmapped bits read as zero
   always @* begin
      case (reg_addr_i)
         `BBT_OFS_TEST_CTRL:  read_mux = {13'h0000, receive_enable_reg,
                                          send_enable_reg, 1'b0};
         `BBT_OFS_LOCAL_ERR:  read_mux = local_error_count_reg;
         `BBT_OFS_SEND_START: read_mux = {2'h0, bp_send_stream_reg, bp_send_channel_reg};
         `BBT_OFS_SEND_LEN:   read_mux = {7'h00, bp_send_length_reg};
         `BBT_OFS_RECV_LEN:   read_mux = {7'h00, bp_receive_length_reg};
         `BBT_OFS_RECV_START: read_mux = {2'h0, bp_receive_stream_reg,
                                          bp_receive_channel_reg};
         default:             read_mux = `BBT_READ_NONE;
      endcase
   end

   // Read data one cycle after the strobe
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o  <= `BBT_READ_NONE;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= read_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Per-frame settings
   // ----------------------------------------------------------------
   // Frame-long copies of the span settings
   reg  [8:0] tx_start_reg;
   reg  [8:0] tx_len_reg;
   reg        tx_en_reg;
   reg  [8:0] rx_start_reg;
   reg  [8:0] rx_len_reg;
   reg  [4:0] rx_stream_reg;
   reg        rx_en_reg;

   // Mid-frame writes wait for the next frame start
   // send settings each frame
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_start_reg   <= 9'h000;
         tx_len_reg     <= 9'h000;
         tx_en_reg      <= 1'b0;
         bp_tx_stream_o <= 5'h00;
      end else if (frame_start_i) begin
         tx_start_reg   <= bp_send_channel_reg;
         tx_len_reg     <= bp_send_length_reg;
         tx_en_reg      <= send_enable_reg;
         bp_tx_stream_o <= bp_send_stream_reg;
      end
   end

   // Receive settings at the same boundary
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_start_reg  <= 9'h000;
         rx_len_reg    <= 9'h000;
         rx_stream_reg <= 5'h00;
         rx_en_reg     <= 1'b0;
      end else if (frame_start_i) begin
         rx_start_reg  <= bp_receive_channel_reg;
         rx_len_reg    <= bp_receive_length_reg;
         rx_stream_reg <= bp_receive_stream_reg;
         rx_en_reg     <= receive_enable_reg;
      end
   end

   // ----------------------------------------------------------------
   // Backplane transmitter
   // ----------------------------------------------------------------
   wire tx_in_span;
   wire tx_step;

   // span opens at the start channel
   assign tx_in_span = in_window(bp_tx_channel_i, tx_start_reg, tx_len_reg);
   assign tx_step    = tx_en_reg && bp_tx_bit_en_i && tx_in_span;

   // Insert flag tracks the bit being driven
   // Frame start drops a flag left from the last frame, unless a bit time in the same cycle reloads it
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bp_tx_insert_o <= 1'b0;
      end else if (bp_tx_bit_en_i) begin
         bp_tx_insert_o <= tx_en_reg && tx_in_span;
      end else if (frame_start_i) begin
         bp_tx_insert_o <= 1'b0;
      end
   end

   // Sequence generator
   bbt_seq u_tx_seq (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .step_i    (tx_step),
      .check_i   (1'b0),
      .rx_bit_i  (1'b0),
      .bit_o     (bp_tx_data_o),
      .err_o     ()
   );

   // ----------------------------------------------------------------
   // Backplane checker
   // ----------------------------------------------------------------
   wire rx_in_span;
   wire rx_step;
   wire rx_bit;

   // Self-synchronising, so the first bits after reset may flag
   // span opens at the start channel
   assign rx_in_span = in_window(bp_rx_channel_i, rx_start_reg, rx_len_reg);
   assign rx_step    = rx_en_reg && bp_rx_bit_en_i && rx_in_span;

   // bit from the chosen input stream
   assign rx_bit = pick_stream(bp_rx_data_i, rx_stream_reg);

   // one error pulse per mismatched bit
   bbt_seq u_rx_seq (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .step_i    (rx_step),
      .check_i   (1'b1),
      .rx_bit_i  (rx_bit),
      .bit_o     (),
      .err_o     (bp_bit_error_o)
   );

endmodule

`default_nettype wire

// file: dv/bbt_top_checker.sv
`default_nettype none
module bbt_top_checker (
   // Clock, reset and register port
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic        reg_rvalid_o,
   // Backplane and local events
   input wire logic        frame_start_i,
   input wire logic        bp_tx_bit_en_i,
   input wire logic [4:0]  bp_tx_stream_o,
   input wire logic        bp_tx_insert_o,
   input wire logic        bp_rx_bit_en_i,
   input wire logic        bp_bit_error_o,
   input wire logic        local_bit_error_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // --------------------------------
   // Reference local error count
   // --------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q <= 16'h0000;
      end else if (reg_wr_i && reg_addr_i == 12'h0BF && reg_wdata_i[0]) begin
         cnt_q <= {15'h0000, local_bit_error_i};
      end else if (local_bit_error_i && cnt_q != 16'hFFFF) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
   AST_RD_ANSWER: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read not answered");
   AST_RVALID_CAUSE: assert property (reg_rvalid_o |-> $past(reg_rd_i))
      else $error("read answer without read");
   AST_RDATA_HOLD: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
      else $error("read data moved");
   AST_LOCAL_COUNT: assert property (reg_rd_i && reg_addr_i == 12'h0C7
      |=> reg_rdata_o == $past(cnt_q)) else $error("local count wrong");
   AST_STREAM_AT_FRAME: assert property (!$stable(bp_tx_stream_o) |-> $past(frame_start_i))
      else $error("send stream changed mid-frame");
   AST_INSERT_CAUSE: assert property ($rose(bp_tx_insert_o) |-> $past(bp_tx_bit_en_i))
      else $error("insert without bit time");
   AST_FRAME_CLEARS: assert property (frame_start_i && !bp_tx_bit_en_i |=> !bp_tx_insert_o)
      else $error("insert kept over frame start");
   AST_ERR_CAUSE: assert property (bp_bit_error_o |-> $past(bp_rx_bit_en_i))
      else $error("error without received bit");
   // Main scenarios reached
   cover property (reg_rd_i && reg_addr_i == 12'h0C7 ##1 reg_rdata_o == 16'hFFFF);
   cover property ($rose(bp_tx_insert_o));
   cover property (bp_bit_error_o);
endmodule
bind bbt_top bbt_top_checker chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
   .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .frame_start_i(frame_start_i),
   .bp_tx_bit_en_i(bp_tx_bit_en_i), .bp_tx_stream_o(bp_tx_stream_o),
   .bp_tx_insert_o(bp_tx_insert_o), .bp_rx_bit_en_i(bp_rx_bit_en_i),
   .bp_bit_error_o(bp_bit_error_o), .local_bit_error_i(local_bit_error_i));
`default_nettype wire

// file: dv/bbt_tdm_far.sv
`default_nettype none
module bbt_tdm_far #(
   parameter int NCH = 16,
   parameter int BPC = 2
) (
   // Clock, reset and bench control
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       flip_i,
   input  wire logic [4:0] rs_i,
   input  wire logic [8:0] st_i,
   input  wire logic [8:0] ln_i,
   // Frame timing and input streams
   output logic            frame_o,
   output logic            bit_en_o,
   output logic [8:0]      chan_o,
   output logic [31:0]     data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        ph_q, fl_q, nxt;
   logic [9:0]  bit_q;
   logic [14:0] seq_q;
   // One bit every second clock
   assign bit_en_o = ph_q;
   assign frame_o  = !ph_q && bit_q == 10'h000;
   assign chan_o   = 9'(bit_q / 10'(BPC));
   assign nxt      = seq_q[14] ^ seq_q[13];
   // Chosen stream carries the sequence, the rest its inverse
   always_comb begin
      data_o       = {32{~nxt}};
      data_o[rs_i] = nxt ^ fl_q;
   end
   // --------------------------------
   // Sequence advances in the span only
   // --------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {ph_q, fl_q, bit_q} <= 12'h000;
         seq_q <= 15'h7FFF;
      end else begin
         ph_q <= !ph_q;
         fl_q <= fl_q | flip_i;
         if (ph_q)
            bit_q <= (bit_q == 10'(NCH * BPC - 1)) ? 10'h000 : bit_q + 10'h001;
         if (ph_q && chan_o >= st_i && {1'b0, chan_o} <= {1'b0, st_i} + {1'b0, ln_i}) begin
            seq_q <= {seq_q[13:0], nxt};
            fl_q  <= flip_i;
         end
      end
   end
endmodule
`default_nettype wire

// file: dv/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BPC = 2;
   localparam int FRM = 64;
   typedef struct packed {logic [11:0] a; logic [15:0] w; logic [15:0] e;} bbt_row_t;
   logic        clk_i, reset_n_i, reg_wr_i, reg_rd_i, local_bit_error_i, flip;
   logic        frame, bit_en, insert, tdata, berr, rvalid, en_d;
   logic [4:0]  stream, rs;
   logic [8:0]  chan, st, ln, ch_d;
   logic [11:0] reg_addr_i;
   logic [15:0] reg_wdata_i, rdata;
   logic [14:0] tx_h;
   logic [31:0] rxd;
   int          bad_count = 0, n_checks = 0, cyc = 0, ins_n = 0, last_ins = 0;
   int          first_ch = 0, err_n = 0, tx_n = 0, tx_bad = 0;
   bbt_row_t    rows [7] = '{'{12'h0C8, 16'h3FFF, 16'h3FFF}, '{12'h0C9, 16'h01FF, 16'h01FF},
      '{12'h0CA, 16'h01FF, 16'h01FF}, '{12'h0CB, 16'h3FFF, 16'h3FFF},
      '{12'h0C7, 16'h1234, 16'h0000}, '{12'h0C0, 16'h5555, 16'h0000},
      '{12'h0BF, 16'h0007, 16'h0006}};
   bbt_top dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .frame_start_i(frame), .bp_tx_bit_en_i(bit_en),
      .bp_tx_channel_i(chan), .bp_tx_stream_o(stream), .bp_tx_insert_o(insert),
      .bp_tx_data_o(tdata), .bp_rx_bit_en_i(bit_en), .bp_rx_channel_i(chan),
      .bp_rx_data_i(rxd), .bp_bit_error_o(berr), .local_bit_error_i(local_bit_error_i));
   bbt_tdm_far far_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .flip_i(flip), .rs_i(rs),
      .st_i(st), .ln_i(ln), .frame_o(frame), .bit_en_o(bit_en), .chan_o(chan), .data_o(rxd));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Watch inserted bits, checker errors and run time
   always @(posedge clk_i) begin
      en_d <= bit_en;
      ch_d <= chan;
      cyc = cyc + 1;
      if (en_d === 1'b1 && insert === 1'b1) begin
         if (ins_n == 0)
            first_ch = ch_d;
         ins_n++;
         if (tx_n >= 15 && tdata !== (tx_h[14] ^ tx_h[13]))
            tx_bad++;
         tx_h = {tx_h[13:0], tdata};
         tx_n++;
      end
      if (berr === 1'b1)
         err_n++;
      if (frame) begin
         last_ins = ins_n;
         ins_n = 0;
      end
      if (cyc == 80000) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_i);
      chk("rvalid", 16'h0001, {15'h0000, rvalid});
      chk($sformatf("reg %h", a), e, rdata);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // --------------------------------
   // Main sequence
   // --------------------------------
   initial begin
      {reset_n_i, reg_wr_i, reg_rd_i, local_bit_error_i, flip} = 5'h00;
      {reg_addr_i, reg_wdata_i, rs, st, ln} = 51'h0;
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      foreach (rows[i]) begin
         rd_chk(rows[i].a, 16'h0000);
         wr(rows[i].a, rows[i].w);
         rd_chk(rows[i].a, rows[i].e);
      end
      $display("register rows done");
      // Send stream 5 channels 3..5, check stream 7 channels 4..8
      wr(12'h0C8, 16'h0A03);
      wr(12'h0C9, 16'h0002);
      wr(12'h0CB, 16'h0E04);
      wr(12'h0CA, 16'h0004);
      {rs, st, ln} <= {5'h07, 9'h004, 9'h004};
      repeat (4 * FRM) @(posedge clk_i);
      err_n = 0;
      tx_bad = 0;
      repeat (2 * FRM) @(posedge clk_i);
      chk("inserted", 16'(3 * BPC), 16'(last_ins));
      chk("first", 16'h0003, 16'(first_ch));
      chk("stream", 16'h0005, {11'h000, stream});
      chk("rx errors", 16'h0000, 16'(err_n));
      chk("tx sequence", 16'h0000, 16'(tx_bad));
      repeat (FRM) @(posedge clk_i);
      chk("next frame", 16'(3 * BPC), 16'(last_ins));
      // One bad bit is seen again 14 and 15 bits on
      err_n = 0;
      flip <= 1'b1;
      @(posedge clk_i);
      flip <= 1'b0;
      repeat (3 * FRM) @(posedge clk_i);
      chk("flip errors", 16'h0003, 16'(err_n));
      wr(12'h0C8, 16'h0A0F);
      wr(12'h0C9, 16'h0000);
      repeat (3 * FRM) @(posedge clk_i);
      chk("one channel", 16'(BPC), 16'(last_ins));
      chk("last channel", 16'h000F, 16'(first_ch));
      $display("backplane spans done");
      @(posedge clk_i);
      local_bit_error_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      local_bit_error_i <= 1'b0;
      rd_chk(12'h0C7, 16'h0005);
      wr(12'h0BF, 16'h0007);
      rd_chk(12'h0C7, 16'h0000);
      @(posedge clk_i);
      local_bit_error_i <= 1'b1;
      repeat (65540) @(posedge clk_i);
      local_bit_error_i <= 1'b0;
      rd_chk(12'h0C7, 16'hFFFF);
      wr(12'h0C7, 16'h0000);
      rd_chk(12'h0C7, 16'hFFFF);
      wr(12'h0BF, 16'h0007);
      rd_chk(12'h0C7, 16'h0000);
      $display("local count done");
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rd_chk(12'h0C8, 16'h0000);
      $display("second reset done");
      print_verdict();
   end
endmodule
`default_nettype wire
